// [rtl/tbrc_fifo.sv]
// Purpose: Packet FIFO between the core and the trace storage
// Assumes: Single clock, flush drops every stored word
// Notes: Full and empty are decoded from the registered count
`timescale 1ns/10ps
`include "tbrc_map.svh"
module tbrc_fifo
    import tbrc_pkg::*;
#(
    parameter int W = `TBRC_PKT_W,
    parameter int DEPTH = `TBRC_FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
            $error("tbrc_fifo: DEPTH must be a power of two >= 2");
    end
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else if (flush)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule : tbrc_fifo

// [rtl/tbrc_map.svh]
// Purpose: Sizes, field positions and codes of the trace control
// Assumes: Included by the FIFO and top-level design files of the trace buffer control
// Notes: Definitions only
`ifndef TBRC_MAP_SVH
`define TBRC_MAP_SVH
`define TBRC_STOP_BIT 31
`define TBRC_HALT_BIT 23
`define TBRC_STATE_HI 22
`define TBRC_STATE_LO 21
`define TBRC_PTR_HI 15
`define TBRC_PTR_LO 8
`define TBRC_CLR_BIT 7
`define TBRC_DIV_BIT 6
`define TBRC_MODE_HI 4
`define TBRC_MODE_LO 3
`define TBRC_SS_HI 2
`define TBRC_SS_LO 0
`define TBRC_CORE_WR_MASK 32'h00FF_FFFF
`define TBRC_SS_OFF 3'h0
`define TBRC_SS_UNCOND 3'h1
`define TBRC_SS_B0_B1 3'h5
`define TBRC_SS_B1_B0 3'h7
`define TBRC_MODE_CONT_BIT 0
`define TBRC_FIFO_DEPTH 8
`define TBRC_PKT_W 8
`define TBRC_BUF_AW 7
`endif

// [rtl/tbrc_pkg.sv]
// Purpose: Types shared by the trace buffer control
// Assumes: Nothing
// Notes: Field codes live in tbrc_map.svh
package tbrc_pkg;
    typedef enum logic [1:0] {
        TBRC_OFF,
        TBRC_WAIT_START,
        TBRC_RECORDING,
        TBRC_FINISHED
    } tbrc_state_t;
endpackage : tbrc_pkg

// [rtl/tbrc_top.sv]
// Purpose: Trace buffer recording control and its configuration register
// Assumes: Storage array, comparators and sync counters sit outside
// Notes: Register state uses por_n; rstn only flushes the packet path
`timescale 1ns/10ps
`include "tbrc_map.svh"
module tbrc_top
    import tbrc_pkg::*;
#(
    parameter int PKT_W = `TBRC_PKT_W,
    parameter int FIFO_DEPTH = `TBRC_FIFO_DEPTH,
    parameter int BUF_AW = `TBRC_BUF_AW
)
(
    // Clock and resets
    input wire logic clk,
    input wire logic rstn,
    input wire logic por_n,
    // Debug host register port
    input wire logic host_wr_en,
    input wire logic [31:0] host_wr_data,
    output logic [31:0] host_rd_data,
    input wire logic host_resume,
    // Core debug write port
    input wire logic core_wr_en,
    input wire logic [23:0] core_wr_data,
    // Breakpoint hits
    input wire logic pc_bp0_hit,
    input wire logic pc_bp1_hit,
    // Trace packets from the core
    input wire logic pkt_valid,
    output logic pkt_ready,
    input wire logic [PKT_W-1:0] pkt_data,
    // Trace storage write port
    output logic buf_wr_en,
    output logic [BUF_AW-1:0] buf_wr_addr,
    output logic [PKT_W-1:0] buf_wr_data,
    input wire logic buf_wr_ready,
    // Status to core and trigger logic
    output logic core_halt_req,
    output logic pc_sync_div16,
    output logic bp0_for_trigger,
    output logic bp1_for_trigger
);
    initial
    begin
        if (BUF_AW < 1 || BUF_AW > 7)
            $error("tbrc_top: BUF_AW must be 1 to 7");
    end

    tbrc_state_t state_r;
    tbrc_state_t state_nxt;
    logic [BUF_AW-1:0] ptr_lo_r;
    logic ptr_wrap_r;
    logic [1:0] mode_r;
    logic [2:0] ss_r;
    logic div16_r;
    logic halt_r;
    logic stop_r;
    logic [31:0] wdata;
    logic [31:0] wmask;
    logic wr_any;
    logic [2:0] ss_new;
    logic continuous;
    logic enable_edge;
    logic buf_clr;
    logic start_hit;
    logic stop_hit;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [PKT_W-1:0] fifo_out_data;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic pop;
    logic last_loc;
    logic [7:0] ptr_field;
    localparam int FW = $clog2(FIFO_DEPTH) + 1;
    logic [FW-1:0] fill_r;
    logic [FW-1:0] fill_nxt;

    // Host write takes priority over a core write in the same cycle
    always_comb
    begin
        wr_any = host_wr_en || core_wr_en;
        if (host_wr_en)
        begin
            wdata = host_wr_data;
            wmask = 32'hFFFF_FFFF;
        end
        else
        begin
            wdata = {8'h00, core_wr_data};
            wmask = `TBRC_CORE_WR_MASK;
        end
    end

    assign ss_new = wdata[`TBRC_SS_HI:`TBRC_SS_LO];
    assign continuous = mode_r[`TBRC_MODE_CONT_BIT];
    assign enable_edge = wr_any && (ss_r == `TBRC_SS_OFF)
        && (ss_new != `TBRC_SS_OFF);
    assign buf_clr = (wr_any && wdata[`TBRC_CLR_BIT])
        || enable_edge
        || (host_resume && continuous);

    // Start and stop sources per start/stop code
    always_comb
    begin
        start_hit = 1'b0;
        stop_hit = 1'b0;
        case (ss_r)
            `TBRC_SS_UNCOND:
                start_hit = 1'b1;
            `TBRC_SS_B0_B1:
            begin
                start_hit = pc_bp0_hit;
                stop_hit = pc_bp1_hit;
            end
            `TBRC_SS_B1_B0:
            begin
                start_hit = pc_bp1_hit;
                stop_hit = pc_bp0_hit;
            end
            default:
            begin
                start_hit = 1'b0;
                stop_hit = 1'b0;
            end
        endcase
    end

    // Recording state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            TBRC_OFF:
            begin
                if (ss_r != `TBRC_SS_OFF)
                    state_nxt = TBRC_WAIT_START;
            end
            TBRC_WAIT_START:
            begin
                if (start_hit)
                    state_nxt = TBRC_RECORDING;
            end
            TBRC_RECORDING:
            begin
                if (stop_hit)
                    state_nxt = TBRC_FINISHED;
            end
            TBRC_FINISHED:
                state_nxt = TBRC_FINISHED;
            default:
                state_nxt = TBRC_OFF;
        endcase
        if (ss_r == `TBRC_SS_OFF)
            state_nxt = TBRC_OFF;
    end

    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            state_r <= TBRC_OFF;
        else if (buf_clr)
            state_r <= TBRC_OFF;
        else
            state_r <= state_nxt;
    end

    // Stop reached flag; set wins over a buffer reset in the same cycle
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            stop_r <= 1'b0;
        else if (state_r == TBRC_RECORDING && stop_hit)
            stop_r <= 1'b1;
        else if (buf_clr)
            stop_r <= 1'b0;
    end

    // Configuration fields
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
        begin
            mode_r <= 2'h0;
            ss_r <= 3'h0;
            div16_r <= 1'b0;
        end
        else if (wr_any)
        begin
            mode_r <= wdata[`TBRC_MODE_HI:`TBRC_MODE_LO];
            ss_r <= ss_new;
            div16_r <= wdata[`TBRC_DIV_BIT];
        end
    end

    // Packet path: accepted only while recording
    assign fifo_in_valid = pkt_valid && pkt_ready
        && (state_r == TBRC_RECORDING) && !halt_r;
    assign fifo_out_ready = (state_r == TBRC_RECORDING) && !halt_r
        && buf_wr_ready && !buf_clr;
    assign pop = fifo_out_valid && fifo_out_ready;
    assign last_loc = (ptr_lo_r == {BUF_AW{1'b1}});

    tbrc_fifo #(
        .W(PKT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .flush(buf_clr),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(pkt_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Mirror of the FIFO fill; ready promises room on the next edge
    always_comb
    begin
        fill_nxt = fill_r;
        if (buf_clr)
            fill_nxt = '0;
        else if ((fifo_in_valid && fifo_in_ready) && !pop)
            fill_nxt = fill_r + 1'b1;
        else if (pop && !(fifo_in_valid && fifo_in_ready))
            fill_nxt = fill_r - 1'b1;
    end

    // Packets offered while idle are taken and dropped, unless the FIFO was left full
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fill_r <= '0;
            pkt_ready <= 1'b0;
        end
        else
        begin
            fill_r <= fill_nxt;
            pkt_ready <= (fill_nxt != FW'(FIFO_DEPTH));
        end
    end

    // Write pointer; por_n only, so system reset leaves it intact
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
        begin
            ptr_lo_r <= '0;
            ptr_wrap_r <= 1'b0;
        end
        else if (buf_clr)
        begin
            ptr_lo_r <= '0;
            ptr_wrap_r <= 1'b0;
        end
        else if (pop)
        begin
            ptr_lo_r <= ptr_lo_r + 1'b1;
            if (last_loc)
                ptr_wrap_r <= 1'b1;
        end
    end

    // Full halt in continuous mode; set wins over a host clear
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            halt_r <= 1'b0;
        else if (pop && last_loc && continuous)
            halt_r <= 1'b1;
        else if (buf_clr)
            halt_r <= 1'b0;
        else if (host_wr_en && !host_wr_data[`TBRC_HALT_BIT])
            halt_r <= 1'b0;
    end

    // Storage write port
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            buf_wr_en <= 1'b0;
            buf_wr_addr <= '0;
            buf_wr_data <= '0;
        end
        else
        begin
            buf_wr_en <= pop;
            if (pop)
            begin
                buf_wr_addr <= ptr_lo_r;
                buf_wr_data <= fifo_out_data;
            end
        end
    end

    // Pointer field: sticky bit on top, low bits in the bottom
    always_comb
    begin
        ptr_field = 8'h00;
        ptr_field[BUF_AW-1:0] = ptr_lo_r;
        ptr_field[7] = ptr_wrap_r;
    end

    // Read-back and side outputs
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
        begin
            host_rd_data <= 32'h0000_0000;
            core_halt_req <= 1'b0;
            pc_sync_div16 <= 1'b0;
            bp0_for_trigger <= 1'b1;
            bp1_for_trigger <= 1'b1;
        end
        else
        begin
            host_rd_data <= 32'h0000_0000;
            host_rd_data[`TBRC_STOP_BIT] <= stop_r;
            host_rd_data[`TBRC_HALT_BIT] <= halt_r;
            host_rd_data[`TBRC_STATE_HI:`TBRC_STATE_LO] <= state_r;
            host_rd_data[`TBRC_PTR_HI:`TBRC_PTR_LO] <= ptr_field;
            host_rd_data[`TBRC_DIV_BIT] <= div16_r;
            host_rd_data[`TBRC_MODE_HI:`TBRC_MODE_LO] <= mode_r;
            host_rd_data[`TBRC_SS_HI:`TBRC_SS_LO] <= ss_r;
            core_halt_req <= halt_r;
            pc_sync_div16 <= div16_r;
            bp0_for_trigger <= !(ss_r == `TBRC_SS_B0_B1
                || ss_r == `TBRC_SS_B1_B0);
            bp1_for_trigger <= !(ss_r == `TBRC_SS_B0_B1
                || ss_r == `TBRC_SS_B1_B0);
        end
    end
endmodule : tbrc_top

// [test/tbrc_storage_model.sv]
// Purpose: Trace storage on the far side
// Assumes: One write per pulse
// Notes: Stalls come from the bench
`timescale 1ns/10ps
module tbrc_storage_model
(
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    // Bench control
    input wire logic stall
);
    logic [7:0] mem [128];
    assign wr_ready = !stall;
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule : tbrc_storage_model

// [test/tbrc_top_assertions.sv]
// Purpose: Port checks of the trace control
// Assumes: Bound to tbrc_top
// Notes: Image lags its fields one cycle
`timescale 1ns/10ps
module tbrc_checker
#(
    parameter int BUF_AW = 7
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic por_n,
    // Register side
    input wire logic host_wr_en,
    input wire logic core_wr_en,
    input wire logic host_resume,
    input wire logic [31:0] host_rd_data,
    // Outputs
    input wire logic buf_wr_en,
    input wire logic [BUF_AW-1:0] buf_wr_addr,
    input wire logic core_halt_req,
    input wire logic pc_sync_div16,
    input wire logic bp0_for_trigger,
    input wire logic bp1_for_trigger
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!por_n);
    logic claim;
    assign claim = host_rd_data[2:0] == 3'h5 || host_rd_data[2:0] == 3'h7;
    sequence s_quiet;
        !host_wr_en && !core_wr_en && !host_resume;
    endsequence
    sequence s_two_writes;
        buf_wr_en ##1 (buf_wr_en && !host_wr_en && !core_wr_en);
    endsequence
    a_clear_reads_zero: assert property (!host_rd_data[7])
        else $error("clear bit read as one");
    a_div_copy: assert property (pc_sync_div16 == host_rd_data[6])
        else $error("divide output differs from field");
    a_halt_copy: assert property (core_halt_req == host_rd_data[23])
        else $error("halt request differs from flag");
    a_halt_cont: assert property ($rose(core_halt_req) |->
        host_rd_data[3]) else $error("halt outside continuous mode");
    a_trigger_claim: assert property (bp0_for_trigger == !claim &&
        bp1_for_trigger == !claim) else $error("breakpoint claim wrong");
    a_addr_step: assert property (s_two_writes |->
        buf_wr_addr == $past(buf_wr_addr) + 1'b1)
        else $error("write address did not step");
    a_ptr_follows: assert property (buf_wr_en ##0 s_quiet |=>
        host_rd_data[14:8] == $past(buf_wr_addr) + 1'b1)
        else $error("pointer not past last write");
    a_sticky_hold: assert property ($fell(host_rd_data[15]) |->
        $past(host_wr_en, 2) || $past(core_wr_en, 2) ||
        $past(host_resume, 2)) else $error("sticky bit dropped");
    a_ptr_keep: assert property ($changed(host_rd_data[14:8]) |->
        $past(buf_wr_en) || $past(host_wr_en, 2) ||
        $past(core_wr_en, 2) || $past(host_resume, 2))
        else $error("pointer moved without cause");
endmodule : tbrc_checker
bind tbrc_top tbrc_checker #(.BUF_AW(BUF_AW)) u_chk (.clk(clk),
    .por_n(por_n), .host_wr_en(host_wr_en), .core_wr_en(core_wr_en),
    .host_resume(host_resume), .host_rd_data(host_rd_data),
    .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr),
    .core_halt_req(core_halt_req), .pc_sync_div16(pc_sync_div16),
    .bp0_for_trigger(bp0_for_trigger), .bp1_for_trigger(bp1_for_trigger));

// [test/trace_buffer_record_control_tb.sv]
// Purpose: Self-checking bench of the trace control
// Assumes: Random packets and stalls, fixed seed
// Notes: Waits cover the two-edge image lag
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module trace_buffer_record_control_tb;
    logic clk, rstn, por_n, hwe, cwe, res, b0, b1, pv, pr, stall;
    logic we, wr_rdy, halt, div, t0, t1;
    logic [31:0] hwd, rd;
    logic [23:0] cwd;
    logic [7:0] pd, wd;
    logic [6:0] wa;
    logic [7:0] exp_mem [128];
    int fail_count, comparisons, cyc, seed, np;
    tbrc_top u_dut (.clk(clk), .rstn(rstn), .por_n(por_n),
        .host_wr_en(hwe), .host_wr_data(hwd), .host_rd_data(rd),
        .host_resume(res), .core_wr_en(cwe), .core_wr_data(cwd),
        .pc_bp0_hit(b0), .pc_bp1_hit(b1), .pkt_valid(pv),
        .pkt_ready(pr), .pkt_data(pd), .buf_wr_en(we),
        .buf_wr_addr(wa), .buf_wr_data(wd), .buf_wr_ready(wr_rdy),
        .core_halt_req(halt), .pc_sync_div16(div),
        .bp0_for_trigger(t0), .bp1_for_trigger(t1));
    tbrc_storage_model u_mem (.clk(clk), .wr_en(we), .wr_addr(wa),
        .wr_data(wd), .wr_ready(wr_rdy), .stall(stall));
    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (e !== g)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [31:0] d);
        hwd = d;
        hwe = 1;
        @(negedge clk);
        hwe = 0;
        repeat (6) @(negedge clk);
    endtask : wr
    task pulse(input int k);
        b0 = k == 0;
        b1 = k == 1;
        res = k == 2;
        @(negedge clk);
        {b0, b1, res} = 3'h0;
        repeat (5) @(negedge clk);
    endtask : pulse
    // Holds valid through a burst; stalls the storage at random
    task send(input int n);
        int k;
        for (int i = 0; i < n; i++)
        begin
            pd = $random(seed);
            pv = 1;
            k = 0;
            while (pr !== 1'b1 && k < 40)
            begin
                @(negedge clk);
                stall = ($random(seed) & 3) == 0;
                k++;
            end
            exp_mem[np % 128] = pd;
            np++;
            @(negedge clk);
            stall = ($random(seed) & 3) == 0;
        end
        pv = 0;
        stall = 0;
        repeat (30) @(negedge clk);
    endtask : send
    task wrap_up;
        $display("Counts: %0d errors in %0d checks", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial
    begin
        seed = 4572;
        {hwe, cwe, res, b0, b1, pv, stall, rstn, por_n} = 9'h000;
        hwd = 32'h0;
        cwd = 24'h0;
        pd = 8'h0;
        repeat (3) @(negedge clk);
        `CHK("image", 32'h0, rd);
        `CHK("trig", 2'h3, {t0, t1});
        {rstn, por_n} = 2'h3;
        @(negedge clk);
        wr(32'h1);
        `CHK("state", 2'h2, rd[22:21]);
        send(20);
        `CHK("ptr", 8'h14, rd[15:8]);
        rstn = 0;
        repeat (3) @(negedge clk);
        rstn = 1;
        repeat (3) @(negedge clk);
        `CHK("kept", 8'h14, rd[15:8]);
        send(120);
        `CHK("wrap", 8'h8C, rd[15:8]);
        for (int i = 0; i < 128; i++)
            `CHK("mem", exp_mem[i], u_mem.mem[i]);
        wr(32'h81);
        np = 0;
        `CHK("clear", 9'h0, {rd[15:8], rd[7]});
        for (int j = 0; j < 2; j++)
        begin
            wr(32'h0);
            `CHK("off", 2'h0, rd[22:21]);
            wr(j ? 32'h7 : 32'h5);
            `CHK("wait", 2'h1, rd[22:21]);
            `CHK("claim", 2'h0, {t0, t1});
            pulse(1 - j);
            `CHK("nostop", 2'h1, rd[22:21]);
            pulse(j);
            `CHK("rec", 2'h2, rd[22:21]);
            pulse(1 - j);
            `CHK("done", 3'h7, {rd[31], rd[22:21]});
        end
        wr(32'h40);
        `CHK("div", 1'b1, div);
        wr(32'h9);
        send(128);
        `CHK("halt", 2'h3, {rd[23], halt});
        pulse(2);
        `CHK("resume", 9'h0, {rd[23], rd[15:8]});
        wr(32'h0);
        cwd = 24'h000001;
        cwe = 1;
        @(negedge clk);
        cwe = 0;
        repeat (6) @(negedge clk);
        `CHK("core", 2'h2, rd[22:21]);
        wrap_up();
    end
endmodule : trace_buffer_record_control_tb
